// [bench/i2c_host_model.sv]
// Behavioural I2C host that drives the redriver's SCL and SDA pins
`timescale 1ns/1ps
module i2c_host_model (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_pull_o
);
  initial begin
    scl_o      = 1'b1;
    sda_pull_o = 1'b0;
  end
  // Four clocks per half(); with the extra clock after SCL falls each bit takes 360 ns
  task automatic half();
    repeat (4) @(posedge clk_i);
  endtask
  // SDA moves one clock after SCL falls so the target never sees a false START or STOP
  task automatic bit_x(input logic b, output logic s);
    sda_pull_o <= ~b;
    half();
    scl_o <= 1'b1;
    half();
    s = sda_i;
    scl_o <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic start();
    sda_pull_o <= 1'b0;
    half();
    scl_o <= 1'b1;
    half();
    sda_pull_o <= 1'b1;
    half();
    scl_o <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic stop();
    sda_pull_o <= 1'b1;
    half();
    scl_o <= 1'b1;
    half();
    sda_pull_o <= 1'b0;
    half();
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(d[i], s);
    bit_x(1'b1, s);
    ack = (s === 1'b0);
  endtask
  // The last byte of a read is refused so the target lets go of SDA
  task automatic rd_byte(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(nack, s);
  endtask
endmodule // i2c_host_model

// [bench/redriver_i2c_config_and_power_control_tb_top.sv]
// Self-checking bench for the redriver register, strap and power-state control
`timescale 1ns/1ps
module redriver_i2c_config_and_power_control_tb_top;
  logic                 clk_i, rst_i, scl, sda_pull, sda_o, sda_oe_o, chip_on, conn, lowp;
  logic                 chan_en_o, squelch_en_o, rterm_ind_o, rterm_det_en_o, rterm_poll_o;
  logic                 term_hiz_o, cm_hold_o, unlocked_o, unl, ack, ce_q;
  logic [1:0]           addr_strap;
  logic [20:0]          straps_i, straps_o, exp_straps;
  logic [63:0]          cfg_main_o;
  logic [7:0]           cfg_ext_o;
  logic [7:0]           mem [0:255];
  logic [6:0]           dev_a;
  logic [6:0]           addr_tab [0:3];
  redriver_pkg::power_t power_state_o;
  int                   n_errors = 0, n_checks = 0, seed, cyc = 0, r;
  // Pull-up on SDA: released means high
  wire                  sda = ~(sda_pull | sda_oe_o);
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  i2c_host_model host_u (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_pull_o(sda_pull));
  redriver_ctrl #(.POLL_CYCLES(8)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .chip_on_input_i(chip_on), .addr_strap_i(addr_strap),
    .straps_i(straps_i), .conn_present_i(conn), .link_lowpower_i(lowp),
    .straps_o(straps_o), .cfg_main_o(cfg_main_o), .cfg_ext_o(cfg_ext_o),
    .unlocked_o(unlocked_o), .power_state_o(power_state_o), .chan_en_o(chan_en_o),
    .squelch_en_o(squelch_en_o), .rterm_ind_o(rterm_ind_o), .rterm_det_en_o(rterm_det_en_o),
    .rterm_poll_o(rterm_poll_o), .term_hiz_o(term_hiz_o), .cm_hold_o(cm_hold_o));
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_errors++;
      $display("timeout after %0d cycles", cyc);
      end_of_test();
    end
  end
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic mdl_reset();
    for (int i = 0; i < 256; i++) mem[i] = 8'h00;
    for (int i = 0; i < 8; i++) mem[i] = redriver_pkg::MAIN_RESET[8*i +: 8];
    mem[8'h40] = redriver_pkg::KEY_RESET;
    mem[8'h41] = redriver_pkg::EXT_RESET;
    unl = 1'b0;
  endtask
  function automatic logic mapped(input logic [7:0] o);
    return o <= 8'h07 || o == 8'h41;
  endfunction
  task automatic mdl_wr(input logic [7:0] o, input logic [7:0] d);
    if (o == 8'h40) begin
      mem[o] = d;
      unl = (d == 8'hAE);
    end else if (unl && mapped(o)) mem[o] = d;
    else if (unl && o == 8'h44 && d[0]) mdl_reset();
  endtask
  function automatic logic [7:0] mdl_rd(input logic [7:0] o);
    return (o == 8'h40 || (unl && mapped(o))) ? mem[o] : 8'h00;
  endfunction
  task automatic chk_regs();
    logic [63:0] m;
    for (int i = 0; i < 8; i++) m[8*i +: 8] = mem[i];
    chk("cfg_main", cfg_main_o, m);
    chk("cfg_ext", cfg_ext_o, mem[8'h41]);
    chk("unlocked", unlocked_o, unl);
    chk("sda out level", sda_o, 1'b0);
  endtask
  task automatic reg_write(input logic [7:0] o, input int n, input logic [31:0] d);
    host_u.start();
    host_u.wr_byte({dev_a, 1'b0}, ack);
    host_u.wr_byte(o, ack);
    for (int i = 0; i < n; i++) begin
      host_u.wr_byte(d[8*i +: 8], ack);
      chk("write ack", ack, 1'b1);
      mdl_wr(o + i[7:0], d[8*i +: 8]);
    end
    host_u.stop();
    chk_regs();
  endtask
  task automatic reg_read(input logic [7:0] o, input int n);
    logic [7:0] b;
    host_u.start();
    host_u.wr_byte({dev_a, 1'b0}, ack);
    host_u.wr_byte(o, ack);
    host_u.stop();
    host_u.start();
    host_u.wr_byte({dev_a, 1'b1}, ack);
    for (int i = 0; i < n; i++) begin
      host_u.rd_byte(i == n - 1, b);
      chk("read byte", b, mdl_rd(o + i[7:0]));
    end
    host_u.stop();
  endtask
  task automatic chk_power();
    logic [7:0] e;
    if (!chip_on) e = {redriver_pkg::PWR_DEEP, 6'b000010};
    else if (!conn || lowp) e = {redriver_pkg::PWR_SAVE, 2'b11, conn, 3'b101};
    else e = {redriver_pkg::PWR_ACTIVE, 6'b101001};
    chk("power", {power_state_o, chan_en_o, squelch_en_o, rterm_ind_o, rterm_det_en_o,
                  term_hiz_o, cm_hold_o}, e);
  endtask
  // Any 80-cycle window of a period-8 train holds exactly ten pulses
  task automatic count_poll(input int exp);
    int c = 0;
    repeat (80) begin
      @(posedge clk_i);
      #1 c += (rterm_poll_o === 1'b1);
    end
    chk("poll pulses", c, exp);
    @(posedge clk_i);
  endtask
  initial begin
    seed = 88569;
    addr_tab = '{7'h12, 7'h16, 7'h1E, 7'h1A};
    rst_i <= 1'b1;
    chip_on <= 1'b1;
    conn <= 1'b1;
    lowp <= 1'b0;
    addr_strap <= 2'h0;
    r = $random(seed);
    straps_i <= r[20:0];
    repeat (6) @(posedge clk_i);
    for (int k = 0; k < 4; k++) begin
      addr_strap <= k[1:0];
      rst_i <= 1'b1;
      @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      dev_a = addr_tab[k];
      host_u.start();
      host_u.wr_byte({dev_a, 1'b0}, ack);
      host_u.stop();
      chk("own address", ack, 1'b1);
      host_u.start();
      host_u.wr_byte({addr_tab[(k + 1) % 4], 1'b0}, ack);
      host_u.stop();
      chk("other address", ack, 1'b0);
    end
    mdl_reset();
    exp_straps = straps_i;
    chk("straps", straps_o, exp_straps);
    chk_regs();
    chk_power();
    count_poll(0);
    $display("test reset_and_address done");
    r = $random(seed);
    reg_write(8'h00, 4, r);
    reg_read(8'h00, 4);
    reg_write(8'h40, 1, 32'h0000_00AE);
    reg_read(8'h40, 1);
    r = $random(seed);
    reg_write(8'h04, 4, r);
    reg_read(8'h04, 4);
    r = $random(seed);
    reg_write(8'h41, 1, r);
    reg_read(8'h41, 1);
    reg_write(8'h40, 1, 32'h0000_005A);
    reg_read(8'h04, 4);
    reg_write(8'h40, 1, 32'h0000_00AE);
    r = $random(seed);
    reg_write(8'h00, 4, r);
    reg_write(8'h44, 1, 32'h0000_0001);
    reg_read(8'h00, 4);
    reg_write(8'h40, 1, 32'h0000_00AE);
    reg_write(8'h04, 4, 32'h1234_5678);
    $display("test registers done");
    ce_q = 1'b1;
    for (int i = 0; i < 16; i++) begin
      r = $random(seed);
      if (i < 8) r[2:0] = i[2:0] ^ 3'h4;
      @(posedge clk_i);
      chip_on <= r[2];
      conn <= r[1];
      lowp <= r[0];
      straps_i <= r[23:3];
      repeat (8) @(posedge clk_i);
      if (r[2] !== ce_q) exp_straps = r[23:3];
      if (r[2] && !ce_q) mdl_reset();
      ce_q = r[2];
      chk("straps", straps_o, exp_straps);
      chk_regs();
      chk_power();
      count_poll((r[2] && (!r[1] || r[0])) ? 10 : 0);
    end
    $display("test power_states done");
    end_of_test();
  end
endmodule // redriver_i2c_config_and_power_control_tb_top

// [hdl/redriver_ctrl.sv]
// Redriver I2C target, register file, chip enable and power-state control
// What this block does
// - Read starts with a write carrying one byte: the register offset.
// - Read data phase returns four bytes, low byte first, host acks all but the last.
// - Write carries offset then four data bytes, low first, device acks each.
// - Transfers may end after one data byte or after four.
// - Four-byte accesses use offsets with two low bits zero.
// - Target address chosen by the level on the address strap.
// - After power-up lock is closed; only offset 0x40 accepts writes.
// - Writing 0xAE to 0x40 opens offsets 0x00-0x07 and 0x41.
// - Reset puts every register and state machine at its default.
// - Chip enable may change at any time after power-on.
// - Chip enable high means active or power saving, low means deep power saving.
// - Seven straps sampled at power-on and on every chip enable toggle.
// - Chip enable rising resets the key, extension and main registers to defaults.
// - Power state follows bus conditions and pins, not link commands.
// - Active: both channels pass data, termination indicated, no detection.
// - Power saving: channels on, squelch, LFPS and detection running.
// - Saving without connection: detection polls, indication dropped.
// - Saving with connection in U2/U3: detection polls, indication kept.
// - Deep saving: terminations high impedance, common mode not held.
// - Writing one to the reset register resets every register; it self-clears.
`timescale 1ns/1ps
module redriver_ctrl #(
  parameter int POLL_CYCLES = redriver_pkg::POLL_CYCLES_DEF
) (
  input  wire logic                                clk_i,
  input  wire logic                                rst_i,
  input  wire logic                                scl_i,
  input  wire logic                                sda_i,
  output logic                                     sda_o,
  output logic                                     sda_oe_o,
  input  wire logic                                chip_on_input_i,
  input  wire logic [1:0]                          addr_strap_i,
  input  wire logic [redriver_pkg::STRAP_W*7-1:0]  straps_i,
  input  wire logic                                conn_present_i,
  input  wire logic                                link_lowpower_i,
  output logic [redriver_pkg::STRAP_W*7-1:0]       straps_o,
  output logic [63:0]                              cfg_main_o,
  output logic [7:0]                               cfg_ext_o,
  output logic                                     unlocked_o,
  output redriver_pkg::power_t                     power_state_o,
  output logic                                     chan_en_o,
  output logic                                     squelch_en_o,
  output logic                                     rterm_ind_o,
  output logic                                     rterm_det_en_o,
  output logic                                     rterm_poll_o,
  output logic                                     term_hiz_o,
  output logic                                     cm_hold_o
);
  localparam int SW = redriver_pkg::STRAP_W * 7;
  localparam int PW = $clog2(POLL_CYCLES + 1);
  localparam int YW = SW + 7;

  // All pin inputs pass two flops; logic reads sync2 and the scl_q, sda_q, chip_q copies, never sync1
  logic [YW-1:0] sync1, sync2;
  logic          scl_q, sda_q, chip_q;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      // Idle bus levels, so no false SCL or SDA edge follows reset
      sync1  <= {2'h3, {(YW-2){1'b0}}};
      sync2  <= {2'h3, {(YW-2){1'b0}}};
      scl_q  <= 1'b1;
      sda_q  <= 1'b1;
      chip_q <= 1'b0;
    end else begin
      sync1  <= {scl_i, sda_i, chip_on_input_i, conn_present_i, link_lowpower_i,
                 addr_strap_i, straps_i};
      sync2  <= sync1;
      scl_q  <= sync2[YW-1];
      sda_q  <= sync2[YW-2];
      chip_q <= sync2[YW-3];
    end
  end
  logic          scl_s, sda_s, chip_s, conn_s, lp_s;
  logic [1:0]    addr_s;
  logic [SW-1:0] strap_s;
  assign {scl_s, sda_s, chip_s, conn_s, lp_s, addr_s, strap_s} = sync2;
  logic scl_rise, scl_fall, start_ev, stop_ev, chip_rise, chip_tog;
  assign scl_rise  = scl_s & ~scl_q;
  assign scl_fall  = ~scl_s & scl_q;
  assign start_ev  = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_ev   = scl_s & scl_q & ~sda_q & sda_s;
  assign chip_tog  = chip_s ^ chip_q;
  assign chip_rise = chip_s & ~chip_q;

  // Straps are caught once the synchronisers hold real pin levels, and on enable toggles
  logic [1:0]    init_cnt, next_init_cnt;
  logic [SW-1:0] strap_lat, next_strap_lat;
  logic [1:0]    addr_lat, next_addr_lat;
  always_comb begin
    next_init_cnt  = (init_cnt == 2'h0) ? 2'h0 : init_cnt - 2'h1;
    next_strap_lat = strap_lat;
    next_addr_lat  = addr_lat;
    if (init_cnt == 2'h1 || chip_tog) begin
      next_strap_lat = strap_s;
      next_addr_lat  = addr_s;
    end
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      init_cnt  <= 2'h3;
      strap_lat <= '0;
      addr_lat  <= redriver_pkg::LVL_OPEN;
    end else begin
      init_cnt  <= next_init_cnt;
      strap_lat <= next_strap_lat;
      addr_lat  <= next_addr_lat;
    end
  end
  assign straps_o = strap_lat;

  logic [6:0] my_addr;
  always_comb begin
    unique case (addr_lat)
      redriver_pkg::LVL_RAIL:   my_addr = redriver_pkg::ADDR_RAIL;
      redriver_pkg::LVL_PULLDN: my_addr = redriver_pkg::ADDR_PULLDN;
      redriver_pkg::LVL_PULLUP: my_addr = redriver_pkg::ADDR_PULLUP;
      redriver_pkg::LVL_OPEN:   my_addr = redriver_pkg::ADDR_OPEN;
    endcase
  end

  // Register file
  logic [7:0]  main [0:7];
  logic [7:0]  next_main [0:7];
  logic [7:0]  key, next_key, ext, next_ext;
  logic        wr_en;
  logic [7:0]  wr_addr, wr_data;
  logic        unlocked, soft_rst, wr_ok;
  assign unlocked = (key == redriver_pkg::UNLOCK_VALUE);
  assign soft_rst = chip_rise
                  | (wr_en && unlocked && wr_addr == redriver_pkg::OFS_RESET && wr_data[0]);
  assign wr_ok    = wr_en && (wr_addr == redriver_pkg::OFS_KEY || unlocked);
  always_comb begin
    next_key = key;
    next_ext = ext;
    for (int i = 0; i < 8; i++) begin
      next_main[i] = main[i];
    end
    if (soft_rst) begin
      next_key = redriver_pkg::KEY_RESET;
      next_ext = redriver_pkg::EXT_RESET;
      for (int i = 0; i < 8; i++) begin
        next_main[i] = redriver_pkg::MAIN_RESET[i*8 +: 8];
      end
    end else if (wr_ok) begin
      if (wr_addr == redriver_pkg::OFS_KEY) begin
        next_key = wr_data;
      end else if (wr_addr == redriver_pkg::OFS_EXT) begin
        next_ext = wr_data;
      end else if (wr_addr <= redriver_pkg::OFS_MAIN_LAST) begin
        next_main[wr_addr[2:0]] = wr_data;
      end
    end
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      key <= redriver_pkg::KEY_RESET;
      ext <= redriver_pkg::EXT_RESET;
      for (int i = 0; i < 8; i++) begin
        main[i] <= redriver_pkg::MAIN_RESET[i*8 +: 8];
      end
    end else begin
      key <= next_key;
      ext <= next_ext;
      for (int i = 0; i < 8; i++) begin
        main[i] <= next_main[i];
      end
    end
  end
  generate
    for (genvar g = 0; g < 8; g++) begin : g_cfg
      assign cfg_main_o[g*8 +: 8] = main[g];
    end
  endgenerate
  assign cfg_ext_o  = ext;
  assign unlocked_o = unlocked;

  function automatic logic [7:0] read_byte(input logic [7:0] a);
    read_byte = 8'h00;
    if (a == redriver_pkg::OFS_KEY) begin
      read_byte = key;
    end else if (unlocked && a == redriver_pkg::OFS_EXT) begin
      read_byte = ext;
    end else if (unlocked && a <= redriver_pkg::OFS_MAIN_LAST) begin
      read_byte = main[a[2:0]];
    end
  endfunction

  // I2C target: sample on SCL rise, change SDA after SCL fall
  redriver_pkg::i2c_st_t st, next_st;
  logic [2:0] bcnt, next_bcnt;
  logic [7:0] sh, next_sh, ptr, next_ptr;
  logic       is_addr, next_is_addr, is_ofs, next_is_ofs, rd, next_rd;
  logic       drv, next_drv;
  logic [7:0] byte_in;
  logic [7:0] rdata;
  assign byte_in = {sh[6:0], sda_s};
  always_comb begin
    next_st      = st;
    next_bcnt    = bcnt;
    next_sh      = sh;
    next_ptr     = ptr;
    next_is_addr = is_addr;
    next_is_ofs  = is_ofs;
    next_rd      = rd;
    next_drv     = drv;
    wr_en        = 1'b0;
    wr_addr      = ptr;
    wr_data      = byte_in;
    rdata        = read_byte(ptr);
    if (stop_ev) begin
      next_st  = redriver_pkg::ST_IDLE;
      next_drv = 1'b0;
    end else if (start_ev) begin
      next_st      = redriver_pkg::ST_RX;
      next_bcnt    = 3'h0;
      next_is_addr = 1'b1;
      next_drv     = 1'b0;
    end else begin
      unique case (st)
        redriver_pkg::ST_IDLE: ;
        redriver_pkg::ST_RX: if (scl_rise) begin
          next_sh   = byte_in;
          next_bcnt = bcnt + 3'h1;
          if (bcnt == 3'h7) begin
            next_st = redriver_pkg::ST_APEND;
            if (is_addr) begin
              next_is_addr = 1'b0;
              next_rd      = byte_in[0];
              next_is_ofs  = ~byte_in[0];
              if (byte_in[7:1] != my_addr) begin
                next_st = redriver_pkg::ST_IDLE;
              end
            end else if (is_ofs) begin
              next_ptr    = byte_in;
              next_is_ofs = 1'b0;
            end else begin
              wr_en    = 1'b1;
              next_ptr = ptr + 8'h01;
            end
          end
        end
        redriver_pkg::ST_APEND: if (scl_fall) begin
          next_st  = redriver_pkg::ST_ACK;
          next_drv = 1'b1;
        end
        redriver_pkg::ST_ACK: if (scl_fall) begin
          if (rd) begin
            next_st  = redriver_pkg::ST_TX;
            next_sh  = rdata;
            next_ptr = ptr + 8'h01;
            next_drv = ~rdata[7];
          end else begin
            next_st  = redriver_pkg::ST_RX;
            next_drv = 1'b0;
          end
        end
        redriver_pkg::ST_TX: begin
          if (scl_rise) begin
            next_bcnt = bcnt + 3'h1;
          end else if (scl_fall) begin
            if (bcnt == 3'h0) begin
              next_st  = redriver_pkg::ST_HACK;
              next_drv = 1'b0;
            end else begin
              next_sh  = {sh[6:0], 1'b0};
              next_drv = ~sh[6];
            end
          end
        end
        redriver_pkg::ST_HACK: begin
          if (scl_rise && sda_s) begin
            next_st = redriver_pkg::ST_IDLE;
          end else if (scl_fall) begin
            next_st  = redriver_pkg::ST_TX;
            next_sh  = rdata;
            next_ptr = ptr + 8'h01;
            next_drv = ~rdata[7];
          end
        end
        default: next_st = redriver_pkg::ST_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st      <= redriver_pkg::ST_IDLE;
      bcnt    <= 3'h0;
      sh      <= 8'h00;
      ptr     <= 8'h00;
      is_addr <= 1'b0;
      is_ofs  <= 1'b0;
      rd      <= 1'b0;
      drv     <= 1'b0;
    end else begin
      st      <= next_st;
      bcnt    <= next_bcnt;
      sh      <= next_sh;
      ptr     <= next_ptr;
      is_addr <= next_is_addr;
      is_ofs  <= next_is_ofs;
      rd      <= next_rd;
      drv     <= next_drv;
    end
  end
  assign sda_o    = 1'b0;
  assign sda_oe_o = drv;

  // Power state from pins and bus conditions only
  redriver_pkg::power_t pst, next_pst;
  logic [PW-1:0] pcnt, next_pcnt;
  logic [7:0]    outs, next_outs;
  always_comb begin
    if (!chip_s) begin
      next_pst = redriver_pkg::PWR_DEEP;
    end else if (!conn_s || lp_s) begin
      next_pst = redriver_pkg::PWR_SAVE;
    end else begin
      next_pst = redriver_pkg::PWR_ACTIVE;
    end
    next_pcnt = '0;
    if (next_pst == redriver_pkg::PWR_SAVE && pcnt != PW'(POLL_CYCLES - 1)) begin
      next_pcnt = pcnt + PW'(1);
    end
    // chan, squelch, ind, det, poll, hiz, cm
    unique case (next_pst)
      redriver_pkg::PWR_ACTIVE: next_outs = 8'h51;
      redriver_pkg::PWR_SAVE:   next_outs = {1'b0, 1'b1, 1'b1, conn_s, 1'b1,
                                  pcnt == PW'(POLL_CYCLES - 1), 1'b0, 1'b1};
      redriver_pkg::PWR_DEEP:   next_outs = 8'h02;
      default:                  next_outs = 8'h02;
    endcase
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pst  <= redriver_pkg::PWR_DEEP;
      pcnt <= '0;
      outs <= 8'h02;
    end else begin
      pst  <= next_pst;
      pcnt <= next_pcnt;
      outs <= next_outs;
    end
  end
  assign power_state_o = pst;
  assign {chan_en_o, squelch_en_o, rterm_ind_o, rterm_det_en_o, rterm_poll_o,
          term_hiz_o, cm_hold_o} = {outs[6:2], outs[1], outs[0]};

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_DEEP_OFF: assert property (!chip_s |=> pst == redriver_pkg::PWR_DEEP)
    else $error("not deep while enable low");
  AST_ACTIVE_ON: assert property (chip_s && conn_s && !lp_s |=>
    pst == redriver_pkg::PWR_ACTIVE && rterm_ind_o && !rterm_det_en_o && chan_en_o)
    else $error("active outputs wrong");
  AST_DEEP_HIZ: assert property (!chip_s |=> term_hiz_o && !cm_hold_o && !chan_en_o)
    else $error("terminations not released in deep state");
  AST_SAVE_NOCONN: assert property (chip_s && !conn_s |=>
    !rterm_ind_o && rterm_det_en_o && chan_en_o && squelch_en_o)
    else $error("saving without connection wrong");
  AST_SAVE_U23: assert property (chip_s && conn_s && lp_s |=> rterm_ind_o && rterm_det_en_o)
    else $error("saving with connection wrong");
  AST_LOCK_DROP: assert property (wr_en && !unlocked && wr_addr != redriver_pkg::OFS_KEY
    && !chip_rise |=> $stable(ext) && $stable(cfg_main_o))
    else $error("locked write changed a register");
  AST_UNLOCK: assert property (wr_en && wr_addr == redriver_pkg::OFS_KEY && !chip_rise
    && wr_data == redriver_pkg::UNLOCK_VALUE |=> unlocked)
    else $error("unlock failed");
  AST_CHIP_RESET: assert property (chip_rise |=> key == redriver_pkg::KEY_RESET
    && cfg_main_o == redriver_pkg::MAIN_RESET)
    else $error("enable rise did not reset");
  AST_SOFT_RESET: assert property (wr_en && unlocked && wr_data[0]
    && wr_addr == redriver_pkg::OFS_RESET |=> !unlocked && cfg_main_o == redriver_pkg::MAIN_RESET)
    else $error("reset register ineffective");
  AST_STRAPS: assert property (chip_tog |=> strap_lat == $past(strap_s))
    else $error("straps not captured");
  AST_ADDR_ACK: assert property (st == redriver_pkg::ST_RX && is_addr && scl_rise
    && bcnt == 3'h7 && byte_in[7:1] == my_addr |=> ##[1:40] sda_oe_o)
    else $error("address not acknowledged");
  COV_UNLOCK: cover property (wr_en && wr_addr == redriver_pkg::OFS_KEY && wr_data == 8'hAE);
  COV_READ:   cover property (st == redriver_pkg::ST_HACK ##[1:40] st == redriver_pkg::ST_TX);
  COV_POLL:   cover property (rterm_poll_o);
endmodule // redriver_ctrl

// [hdl/redriver_pkg.sv]
// Constants shared by the redriver control block
package redriver_pkg;
  localparam logic [7:0]  OFS_MAIN_LAST   = 8'h07;
  localparam logic [7:0]  OFS_KEY         = 8'h40;
  localparam logic [7:0]  OFS_EXT         = 8'h41;
  localparam logic [7:0]  OFS_RESET       = 8'h44;
  localparam logic [7:0]  UNLOCK_VALUE    = 8'hAE;
  localparam logic [7:0]  KEY_RESET       = 8'h00;
  localparam logic [7:0]  EXT_RESET       = 8'h00;
  // Byte 7 in the top lane down to byte 0 in the low lane
  localparam logic [63:0] MAIN_RESET      = 64'h388D_8000_0000_0000;
  localparam logic [1:0]  LVL_RAIL        = 2'h0;
  localparam logic [1:0]  LVL_PULLDN      = 2'h1;
  localparam logic [1:0]  LVL_PULLUP      = 2'h2;
  localparam logic [1:0]  LVL_OPEN        = 2'h3;
  localparam logic [6:0]  ADDR_RAIL       = 7'h12;
  localparam logic [6:0]  ADDR_PULLDN     = 7'h16;
  localparam logic [6:0]  ADDR_PULLUP     = 7'h1E;
  localparam logic [6:0]  ADDR_OPEN       = 7'h1A;
  localparam int          STRAP_W         = 3;
  localparam int          CLK_MHZ         = 25;
  localparam int          POLL_TIME_US    = 1000;
  localparam int          POLL_CYCLES_DEF = POLL_TIME_US * CLK_MHZ;
  typedef enum logic [1:0] {
    PWR_ACTIVE = 2'b00,
    PWR_SAVE   = 2'b01,
    PWR_DEEP   = 2'b10
  } power_t;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_RX    = 3'b001,
    ST_APEND = 3'b010,
    ST_ACK   = 3'b011,
    ST_TX    = 3'b100,
    ST_HACK  = 3'b101
  } i2c_st_t;
endpackage
